// [design/ebcsd_params.svh]
// Constants for the external bus and chip-select decode block.
`ifndef EBCSD_PARAMS_SVH
`define EBCSD_PARAMS_SVH
`define EBCSD_NUM_SEL 6
`define EBCSD_LAST_SEL 3'h5
`define EBCSD_MODBASE_CODE 12'hc0f
`define EBCSD_MODBASE_V 0
`define EBCSD_MODBASE_MASK_LSB 1
`define EBCSD_MODBASE_BASE_LSB 10
`define EBCSD_MODBASE_RESET 32'h00000000
`define EBCSD_RANGE_LSB 8
`define EBCSD_CS_PAGE 3'h1
`define EBCSD_SUB_BASE 2'h0
`define EBCSD_SUB_MASK 2'h1
`define EBCSD_SUB_CTRL 2'h2
`define EBCSD_CTRL_W 9
`define EBCSD_CTRL_V 0
`define EBCSD_CTRL_WS_LSB 1
`define EBCSD_CTRL_INT 4
`define EBCSD_CTRL_BURST 5
`define EBCSD_CTRL_BYTE 6
`define EBCSD_CTRL_WP 7
`define EBCSD_CTRL_ACK 8
`define EBCSD_BOOT_ONEHOT 6'h01
`define EBCSD_BOOT_WAITS 3'h7
`define EBCSD_ACK_SPACE 3'h7
`define EBCSD_ACK_FILL 27'h7ffffff
`define EBCSD_IRQ_EN_DELAY 5'h10
`endif

// [design/ebcsd_pkg.sv]
// Types shared by the external bus and chip-select decode block.
package ebcsd_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_INT = 6'h02,
    ST_ADDR = 6'h04,
    ST_WAIT = 6'h08,
    ST_GAP = 6'h10,
    ST_DONE = 6'h20
  } ebcsd_state_t;
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } ebcsd_size_t;
endpackage : ebcsd_pkg

// [design/ebcsd_reset_strap.sv]
// Reset-time strap capture and the interrupt enable delay.
`timescale 1ns/1ns
`default_nettype none
`include "ebcsd_params.svh"
module ebcsd_reset_strap (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Straps
  input wire logic interruptRequestZeroN,
  input wire logic bootPortWidthStrap,
  // Captured state
  output logic startStrobeEn,
  output logic bootByte,
  output logic irqEnable
);
  import ebcsd_pkg::*;
  logic strapMeta_reg;
  logic strapSync_reg;
  logic startStrobeEn_reg;
  logic bootByte_reg;
  logic [4:0] delayCnt_reg;

  // The width strap is asynchronous to us, so it is synchronised first.
  always_ff @(posedge ref_clk) begin
    strapMeta_reg <= bootPortWidthStrap;
    strapSync_reg <= strapMeta_reg;
  end

  // The last edge with reset high holds the sample that counts.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      startStrobeEn_reg <= ~interruptRequestZeroN;
      bootByte_reg <= ~strapSync_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      delayCnt_reg <= 5'h00;
    end else if (delayCnt_reg != `EBCSD_IRQ_EN_DELAY) begin
      delayCnt_reg <= delayCnt_reg + 5'h01;
    end
  end

  assign startStrobeEn = startStrobeEn_reg;
  assign bootByte = bootByte_reg;
  assign irqEnable = (delayCnt_reg == `EBCSD_IRQ_EN_DELAY);

  a_irq_en_delay: assert property (@(posedge ref_clk) disable iff (srst)
    $fell(srst) |-> ##15 !irqEnable ##1 irqEnable)
    else $error("interrupt enable not exactly 16 clocks after reset");
  // Once up the enable stays up, so low at the fifteenth clock means low throughout.
  a_irq_en_hold: assert property (@(posedge ref_clk) disable iff (srst)
    irqEnable |=> irqEnable)
    else $error("interrupt enable dropped outside reset");
  a_start_strap: assert property (@(posedge ref_clk) disable iff (srst)
    $fell(srst) |-> (startStrobeEn == !$past(interruptRequestZeroN)))
    else $error("start strobe enable does not follow strap");
endmodule : ebcsd_reset_strap
`default_nettype wire

// [design/ebcsd_cs_match.sv]
// Chip-select range decoder with fixed priority and boot override.
`timescale 1ns/1ns
`default_nettype none
`include "ebcsd_params.svh"
module ebcsd_cs_match (
  // Access under decode
  input wire logic [31:0] addr,
  input wire logic [2:0] space,
  input wire logic isWrite,
  // Boot state
  input wire logic bootMode,
  input wire logic bootByte,
  // Select programming
  input wire logic [23:0] selBase [`EBCSD_NUM_SEL],
  input wire logic [23:0] selMask [`EBCSD_NUM_SEL],
  input wire logic [`EBCSD_CTRL_W-1:0] selCtrl [`EBCSD_NUM_SEL],
  // Decode result
  output logic hit,
  output logic [`EBCSD_NUM_SEL-1:0] selOneHot,
  output logic [2:0] waits,
  output logic internalTerm,
  output logic burstEn,
  output logic bytePort
);
  import ebcsd_pkg::*;
  logic [`EBCSD_NUM_SEL-1:0] rawHit;

  for (genvar g = 0; g < `EBCSD_NUM_SEL; g++) begin : g_match
    logic spaceOk;
    assign spaceOk = selCtrl[g][`EBCSD_CTRL_ACK] ? (space == `EBCSD_ACK_SPACE)
                                                : (space != `EBCSD_ACK_SPACE);
    assign rawHit[g] = selCtrl[g][`EBCSD_CTRL_V] && spaceOk
                       && (((addr[31:`EBCSD_RANGE_LSB] ^ selBase[g]) & selMask[g]) == 24'h000000)
                       && !(isWrite && selCtrl[g][`EBCSD_CTRL_WP]);
  end

  // Ascending scan lets the highest-numbered match overwrite the rest.
  always_comb begin
    hit = 1'b0;
    selOneHot = '0;
    waits = 3'h0;
    internalTerm = 1'b1;
    burstEn = 1'b0;
    bytePort = 1'b0;
    if (bootMode) begin
      hit = 1'b1;
      selOneHot = `EBCSD_BOOT_ONEHOT;
      waits = `EBCSD_BOOT_WAITS;
      bytePort = bootByte;
    end else begin
      for (int i = 0; i < `EBCSD_NUM_SEL; i++) begin
        if (rawHit[i]) begin
          hit = 1'b1;
          selOneHot = '0;
          selOneHot[i] = 1'b1;
          waits = selCtrl[i][`EBCSD_CTRL_WS_LSB +: 3];
          internalTerm = selCtrl[i][`EBCSD_CTRL_INT];
          burstEn = selCtrl[i][`EBCSD_CTRL_BURST];
          bytePort = selCtrl[i][`EBCSD_CTRL_BYTE];
        end
      end
    end
  end
endmodule : ebcsd_cs_match
`default_nettype wire

// [design/ebcsd_bus_ctrl.sv]
// External bus controller: base register, chip-selects and bus cycle sequencing.
`timescale 1ns/1ns
`default_nettype none
`include "ebcsd_params.svh"
// Operation
// - Zero-wait bursts keep control strobes asserted between subtransfers.
// - Byte-port writes assert the upper byte strobe with data on upper lanes.
// - Acknowledge cycle reads CPU space; level on address 4:2, zeros 1:0, ones above.
// - A select qualified for acknowledge space may flag acknowledge cycles.
// - Autovectored acknowledge still runs externally; bus vector ignored.
// - Autovectored acknowledge ends internally with zero wait states.
// - Start strobe enabled when request line zero low before reset release.
// - Interrupts stay disabled sixteen clocks after reset release.
// - 32-bit base register by control code, reset clears valid bit.
// - Internal block decoded on 1-kbyte base only while valid is set.
// - Reserved internal locations read zero and ignore writes.
// - Masked or outside accesses go to the external bus.
// - Six selects, each with base, range and function on 256-byte steps.
// - External access with no matching select raises a transfer error.
// - Internally terminated selects insert zero to seven programmed wait states.
// - Boot select asserts on every external access until its valid bit.
// - Boot mode uses seven wait states and the strapped port width.
// - Boot mode answers every space, no write protect, others blocked.
// - After valid, boot select decodes its range; boot mode returns on reset.
// - Overlapping ranges assert one select, highest number winning.
// - Bus sequencing on rising edge; control strobes change on falling edge.
// - Bursting per select, on internally terminated reads only; inhibited bursts negate strobes between subtransfers.
module ebcsd_bus_ctrl (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Control register move port
  input wire logic ctlWrite,
  input wire logic [11:0] ctlCode,
  input wire logic [31:0] ctlWdata,
  output logic [31:0] ctlRdata,
  // Core request
  input wire logic reqValid,
  output logic reqReady,
  input wire logic [31:0] reqAddr,
  input wire logic [2:0] reqSpace,
  input wire logic reqWrite,
  input wire ebcsd_pkg::ebcsd_size_t reqSize,
  input wire logic [31:0] reqWdata,
  input wire logic reqAckCycle,
  input wire logic [2:0] reqAckLevel,
  input wire logic reqAutovec,
  // Core response
  output logic rspDone,
  output logic rspError,
  output logic rspAutovec,
  output logic [31:0] rspRdata,
  // External bus
  output logic [31:0] extAddr,
  output logic [15:0] extDataOut,
  output logic extDataOe,
  input wire logic [15:0] extDataIn,
  output logic [`EBCSD_NUM_SEL-1:0] selectStrobeN,
  output logic readStrobeN,
  output logic writeStrobeN,
  output logic upperByteStrobeN,
  output logic lowerByteStrobeN,
  output logic transferStartStrobeN,
  input wire logic transferAcknowledgeInN,
  // Straps and interrupt gate
  input wire logic interruptRequestZeroN,
  input wire logic bootPortWidthStrap,
  output logic irqEnable
);
  import ebcsd_pkg::*;
  ebcsd_state_t state_reg;
  ebcsd_state_t state_next;
  logic [31:0] modBase_reg;
  logic [23:0] selBase_reg [`EBCSD_NUM_SEL];
  logic [23:0] selMask_reg [`EBCSD_NUM_SEL];
  logic [`EBCSD_CTRL_W-1:0] selCtrl_reg [`EBCSD_NUM_SEL];
  logic bootMode_reg;
  logic [31:0] curAddr_reg;
  logic curWrite_reg;
  ebcsd_size_t curSize_reg;
  logic [31:0] wdRaw_reg;
  logic [31:0] wshift_reg;
  logic [31:0] rdata_reg;
  logic [`EBCSD_NUM_SEL-1:0] sel_reg;
  logic [2:0] waits_reg;
  logic [2:0] waitCnt_reg;
  logic intTerm_reg;
  logic burst_reg;
  logic byte_reg;
  logic ackCycle_reg;
  logic autovec_reg;
  logic err_reg;
  logic hold_reg;
  logic [1:0] subLeft_reg;
  logic [1:0] nSubM1;
  logic [31:0] effAddr;
  logic [2:0] effSpace;
  logic effWrite;
  logic internalHit;
  logic decHit;
  logic [`EBCSD_NUM_SEL-1:0] decSel;
  logic [2:0] decWaits;
  logic decInt;
  logic decBurst;
  logic decByte;
  logic startStrobeEn;
  logic bootByte;
  logic accept;
  logic term;
  logic shift8;
  logic strobeActive;
  logic upperIntent;
  logic lowerIntent;
  logic [9:0] intOff;
  logic [2:0] intIdx;
  logic [1:0] intSub;
  logic intSel;
  logic intWr;
  logic [31:0] intRd;
  logic [7:0] lane8;

  ebcsd_reset_strap u_strap (
    .ref_clk(ref_clk),
    .srst(srst),
    .interruptRequestZeroN(interruptRequestZeroN),
    .bootPortWidthStrap(bootPortWidthStrap),
    .startStrobeEn(startStrobeEn),
    .bootByte(bootByte),
    .irqEnable(irqEnable)
  );

  // Acknowledge cycles carry their level in the address and ride in CPU space.
  assign effAddr = reqAckCycle ? {`EBCSD_ACK_FILL, reqAckLevel, 2'h0} : reqAddr;
  assign effSpace = reqAckCycle ? `EBCSD_ACK_SPACE : reqSpace;
  assign effWrite = reqAckCycle ? 1'b0 : reqWrite;

  ebcsd_cs_match u_match (
    .addr(effAddr),
    .space(effSpace),
    .isWrite(effWrite),
    .bootMode(bootMode_reg),
    .bootByte(bootByte),
    .selBase(selBase_reg),
    .selMask(selMask_reg),
    .selCtrl(selCtrl_reg),
    .hit(decHit),
    .selOneHot(decSel),
    .waits(decWaits),
    .internalTerm(decInt),
    .burstEn(decBurst),
    .bytePort(decByte)
  );

  // Base register, reached only through the control register move port.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      modBase_reg <= `EBCSD_MODBASE_RESET;
    end else if (ctlWrite && (ctlCode == `EBCSD_MODBASE_CODE)) begin
      modBase_reg <= ctlWdata;
    end
  end
  assign ctlRdata = (ctlCode == `EBCSD_MODBASE_CODE) ? modBase_reg : 32'h00000000;

  assign internalHit = modBase_reg[`EBCSD_MODBASE_V] && !reqAckCycle
                       && (effAddr[31:`EBCSD_MODBASE_BASE_LSB]
                           == modBase_reg[31:`EBCSD_MODBASE_BASE_LSB])
                       && !modBase_reg[`EBCSD_MODBASE_MASK_LSB + effSpace];

  // Internal register block: per-select base, mask and control words.
  assign intOff = curAddr_reg[9:0];
  assign intIdx = intOff[6:4];
  assign intSub = intOff[3:2];
  assign intSel = (intOff[9:7] == `EBCSD_CS_PAGE) && (intIdx <= `EBCSD_LAST_SEL)
                  && (intSub != 2'h3);
  assign intWr = (state_reg == ST_INT) && curWrite_reg && intSel;

  always_comb begin
    intRd = 32'h00000000;
    if (intSel) begin
      case (intSub)
        `EBCSD_SUB_BASE: intRd = {selBase_reg[intIdx], 8'h00};
        `EBCSD_SUB_MASK: intRd = {selMask_reg[intIdx], 8'h00};
        `EBCSD_SUB_CTRL: intRd = {23'h000000, selCtrl_reg[intIdx]};
        default: intRd = 32'h00000000;
      endcase
    end
  end

  for (genvar g = 0; g < `EBCSD_NUM_SEL; g++) begin : g_selreg
    always_ff @(posedge ref_clk) begin
      if (srst) begin
        selBase_reg[g] <= 24'h000000;
        selMask_reg[g] <= 24'h000000;
        selCtrl_reg[g] <= '0;
      end else if (intWr && (intIdx == 3'(g))) begin
        case (intSub)
          `EBCSD_SUB_BASE: selBase_reg[g] <= wdRaw_reg[31:`EBCSD_RANGE_LSB];
          `EBCSD_SUB_MASK: selMask_reg[g] <= wdRaw_reg[31:`EBCSD_RANGE_LSB];
          `EBCSD_SUB_CTRL: selCtrl_reg[g] <= wdRaw_reg[`EBCSD_CTRL_W-1:0];
          default: selBase_reg[g] <= selBase_reg[g];
        endcase
      end
    end
  end

  // Only a system reset can bring boot mode back.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bootMode_reg <= 1'b1;
    end else if (intWr && (intIdx == 3'h0) && (intSub == `EBCSD_SUB_CTRL)
                 && wdRaw_reg[`EBCSD_CTRL_V]) begin
      bootMode_reg <= 1'b0;
    end
  end

  // Subtransfer count: operand bytes divided by port bytes, minus one.
  always_comb begin
    case (reqSize)
      SZ_WORD: nSubM1 = decByte ? 2'h1 : 2'h0;
      SZ_LONG: nSubM1 = decByte ? 2'h3 : 2'h1;
      default: nSubM1 = 2'h0;
    endcase
  end

  assign reqReady = (state_reg == ST_IDLE);
  assign accept = reqValid && reqReady;
  assign term = (state_reg == ST_WAIT)
                && (intTerm_reg ? (waitCnt_reg == waits_reg) : !transferAcknowledgeInN);

  always_comb begin
    case (state_reg)
      ST_IDLE: begin
        if (!reqValid) begin
          state_next = ST_IDLE;
        end else if (internalHit) begin
          state_next = ST_INT;
        end else if (!decHit && !(reqAckCycle && reqAutovec)) begin
          state_next = ST_DONE;
        end else begin
          state_next = ST_ADDR;
        end
      end
      ST_INT: state_next = ST_DONE;
      ST_ADDR: state_next = ST_WAIT;
      ST_WAIT: begin
        if (!term) begin
          state_next = ST_WAIT;
        end else if (subLeft_reg == 2'h0) begin
          state_next = ST_DONE;
        end else if (burst_reg && (waits_reg != 3'h0)) begin
          state_next = ST_ADDR;
        end else begin
          state_next = ST_GAP;
        end
      end
      ST_GAP: state_next = ST_ADDR;
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Transfer attributes are frozen at acceptance.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      curAddr_reg <= 32'h00000000;
      curWrite_reg <= 1'b0;
      curSize_reg <= SZ_BYTE;
      wdRaw_reg <= 32'h00000000;
      sel_reg <= '0;
      waits_reg <= 3'h0;
      intTerm_reg <= 1'b1;
      burst_reg <= 1'b0;
      byte_reg <= 1'b0;
      ackCycle_reg <= 1'b0;
      autovec_reg <= 1'b0;
      err_reg <= 1'b0;
      subLeft_reg <= 2'h0;
    end else if (accept) begin
      curAddr_reg <= effAddr;
      curWrite_reg <= effWrite;
      curSize_reg <= reqSize;
      wdRaw_reg <= reqWdata;
      sel_reg <= decHit ? decSel : '0;
      autovec_reg <= reqAckCycle && reqAutovec;
      ackCycle_reg <= reqAckCycle;
      waits_reg <= (reqAckCycle && reqAutovec) ? 3'h0 : decWaits;
      intTerm_reg <= (reqAckCycle && reqAutovec) ? 1'b1 : decInt;
      burst_reg <= decBurst && decInt && !effWrite;
      byte_reg <= decByte;
      err_reg <= !internalHit && !decHit && !(reqAckCycle && reqAutovec);
      subLeft_reg <= nSubM1;
    end else if (term) begin
      curAddr_reg <= curAddr_reg + (byte_reg ? 32'h00000001 : 32'h00000002);
      subLeft_reg <= subLeft_reg - 2'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      waitCnt_reg <= 3'h0;
      hold_reg <= 1'b0;
    end else if (state_reg == ST_ADDR) begin
      waitCnt_reg <= 3'h0;
    end else if ((state_reg == ST_WAIT) && !term) begin
      waitCnt_reg <= waitCnt_reg + 3'h1;
    end else if (term) begin
      hold_reg <= burst_reg;
    end
  end

  // Byte lanes shift big-end first so the lowest address moves first.
  assign shift8 = byte_reg || (curSize_reg == SZ_BYTE);
  assign lane8 = (byte_reg || !curAddr_reg[0]) ? extDataIn[15:8] : extDataIn[7:0];

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wshift_reg <= 32'h00000000;
      rdata_reg <= 32'h00000000;
    end else if (accept) begin
      rdata_reg <= 32'h00000000;
      case (reqSize)
        SZ_BYTE: wshift_reg <= {reqWdata[7:0], 24'h000000};
        SZ_WORD: wshift_reg <= {reqWdata[15:0], 16'h0000};
        default: wshift_reg <= reqWdata;
      endcase
    end else if ((state_reg == ST_INT) && !curWrite_reg) begin
      rdata_reg <= intRd;
    end else if (term) begin
      wshift_reg <= shift8 ? {wshift_reg[23:0], 8'h00} : {wshift_reg[15:0], 16'h0000};
      if (!curWrite_reg && !autovec_reg) begin
        rdata_reg <= shift8 ? {rdata_reg[23:0], lane8} : {rdata_reg[15:0], extDataIn};
      end
    end
  end

  assign strobeActive = (state_reg == ST_ADDR) || (state_reg == ST_WAIT)
                        || ((state_reg == ST_GAP) && hold_reg);
  assign upperIntent = byte_reg || !shift8 || !curAddr_reg[0];
  assign lowerIntent = !byte_reg && (!shift8 || curAddr_reg[0]);

  // Strobes are retimed to the falling edge, half a clock after sequencing.
  always_ff @(negedge ref_clk) begin
    if (srst) begin
      selectStrobeN <= '1;
      readStrobeN <= 1'b1;
      writeStrobeN <= 1'b1;
      upperByteStrobeN <= 1'b1;
      lowerByteStrobeN <= 1'b1;
      transferStartStrobeN <= 1'b1;
      extDataOut <= 16'h0000;
      extDataOe <= 1'b0;
    end else begin
      selectStrobeN <= ~(sel_reg & {`EBCSD_NUM_SEL{strobeActive}});
      readStrobeN <= !(strobeActive && !curWrite_reg);
      writeStrobeN <= !(strobeActive && curWrite_reg);
      upperByteStrobeN <= !(strobeActive && upperIntent);
      lowerByteStrobeN <= !(strobeActive && lowerIntent);
      transferStartStrobeN <= !(startStrobeEn && (state_reg == ST_ADDR));
      extDataOut <= shift8 ? {wshift_reg[31:24], wshift_reg[31:24]} : wshift_reg[31:16];
      extDataOe <= strobeActive && curWrite_reg;
    end
  end

  assign extAddr = curAddr_reg;
  assign rspDone = (state_reg == ST_DONE);
  assign rspError = rspDone && err_reg;
  assign rspAutovec = rspDone && autovec_reg;
  assign rspRdata = rdata_reg;

  a_burst_hold: assert property (@(posedge ref_clk) disable iff (srst)
    (term && (subLeft_reg != 2'h0) && burst_reg && (waits_reg == 3'h0))
    |=> strobeActive [*2])
    else $error("zero-wait burst dropped strobes between beats");
  a_inhibit_gap: assert property (@(posedge ref_clk) disable iff (srst)
    (term && (subLeft_reg != 2'h0) && !burst_reg) |=> !strobeActive ##1 strobeActive)
    else $error("burst-inhibited beat did not negate strobes");
  a_upper_byte: assert property (@(posedge ref_clk) disable iff (srst)
    (strobeActive && curWrite_reg && byte_reg) |-> upperIntent && !lowerIntent)
    else $error("byte port write missed upper strobe");
  a_ack_addr: assert property (@(posedge ref_clk) disable iff (srst)
    (state_reg == ST_ADDR && ackCycle_reg)
    |-> (curAddr_reg[31:5] == `EBCSD_ACK_FILL) && (curAddr_reg[1:0] == 2'h0) && !curWrite_reg)
    else $error("acknowledge address malformed");
  a_autovec_zero: assert property (@(posedge ref_clk) disable iff (srst)
    (state_reg == ST_ADDR && autovec_reg) |-> ##1 term)
    else $error("autovector cycle not zero-wait");
  a_wait_two: assert property (@(posedge ref_clk) disable iff (srst)
    (state_reg == ST_ADDR && intTerm_reg && waits_reg == 3'h2)
    |-> ##1 !term ##1 !term ##1 term)
    else $error("two wait states not honoured");
  a_nohit_error: assert property (@(posedge ref_clk) disable iff (srst)
    (accept && !internalHit && !decHit && !(reqAckCycle && reqAutovec)) |=> rspDone && rspError)
    else $error("unmatched access not refused");
  a_boot_only: assert property (@(posedge ref_clk) disable iff (srst)
    (bootMode_reg && state_reg == ST_ADDR) |-> (sel_reg == `EBCSD_BOOT_ONEHOT))
    else $error("other select active in boot mode");
  a_one_select: assert property (@(posedge ref_clk) disable iff (srst)
    $onehot0(sel_reg))
    else $error("more than one select chosen");
endmodule : ebcsd_bus_ctrl
`default_nettype wire

// [testbench/ebcsd_bus_model.sv]
// Behavioural model of the memories and strap drivers on the external bus.
`timescale 1ns/1ns
`default_nettype none
module ebcsd_bus_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Bus from the block
  input wire logic [31:0] extAddr,
  input wire logic [5:0] selectStrobeN,
  input wire logic readStrobeN,
  // Answers and straps
  output logic [15:0] extDataIn,
  output logic transferAcknowledgeInN,
  output logic interruptRequestZeroN,
  output logic bootPortWidthStrap
);
  logic [15:0] lastData = 16'h0;
  logic [1:0] relCnt = 2'h0;
  wire logic drive = !readStrobeN && !(&selectStrobeN);
  // Memory holds the inverted address; a released bus shows the inverse of the last value.
  assign extDataIn = drive ? ~extAddr[15:0] : ~lastData;
  // Every select in use is internally terminated, so acknowledge rests at its pull-up.
  assign transferAcknowledgeInN = 1'b1;
  // Width is driven high at all times, through reset and after it, at one constant level.
  assign bootPortWidthStrap = 1'b1;
  // Request zero is held low through reset and let go three clocks after it.
  assign interruptRequestZeroN = !srst && relCnt == 2'h3;
  always @(posedge ref_clk) begin
    if (drive) lastData <= ~extAddr[15:0];
    relCnt <= srst ? 2'h0 : relCnt + {1'b0, relCnt != 2'h3};
  end
endmodule : ebcsd_bus_model
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the external bus and chip-select decode block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import ebcsd_pkg::*;
  logic ref_clk = 0, srst = 1, ctlWrite = 0, reqValid = 0, reqWrite = 0, reqAckCycle = 0;
  logic reqAutovec = 0, reqReady, rspDone, rspError, rspAutovec, extDataOe, readStrobeN;
  logic writeStrobeN, upperByteStrobeN, lowerByteStrobeN, transferStartStrobeN, irqEnable;
  logic transferAcknowledgeInN, interruptRequestZeroN, bootPortWidthStrap, pv, pu;
  logic [11:0] ctlCode = 12'hc0f;
  logic [31:0] ctlWdata = 32'h0, reqAddr = 32'h0, reqWdata = 32'h0, ctlRdata, rspRdata;
  logic [31:0] extAddr, a, d, ea, wv;
  logic [2:0] reqSpace = 3'h0, reqAckLevel = 3'h1;
  logic [15:0] extDataOut, extDataIn, wo;
  logic [5:0] selectStrobeN, sl;
  ebcsd_size_t reqSize = SZ_BYTE;
  int errorCnt = 0, nChecks = 0, lat, rs, ub, at, k;
  ebcsd_bus_ctrl u_ebcsd_bus_ctrl (.*);
  ebcsd_bus_model u_ebcsd_bus_model (.*);
  always #25 ref_clk = ~ref_clk;
  function automatic int elat(int n, int w, bit bst);
    return (bst && w > 0) ? n * (w + 2) : n * (w + 3) - 1;
  endfunction : elat
  function automatic logic [15:0] mem(logic [31:0] x);
    return ~x[15:0];
  endfunction : mem
  task chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task ctl(input logic [11:0] c, input logic [31:0] v);
    {ctlCode, ctlWdata, ctlWrite} = {c, v, 1'b1};
    @(posedge ref_clk);
    #5 ctlWrite = 0;
  endtask : ctl
  // Strobes change on the falling edge, so they are sampled settled just after each rising edge.
  task acc(input logic [31:0] ad, input logic [2:0] sp, input logic wr, input ebcsd_size_t sz,
      input logic [31:0] wd);
    {reqAddr, reqSpace, reqWrite, reqWdata, reqValid} = {ad, sp, wr, wd, 1'b1};
    reqSize = sz;
    {sl, pv, pu, wo, rs, ub, at, lat} = {6'h0, 2'h3, 144'h0};
    do @(posedge ref_clk); while (reqReady !== 1'b1);
    #5 reqValid = 0;
    while (rspDone !== 1'b1 && lat < 60) begin
      ea = extAddr;
      @(posedge ref_clk);
      #5 lat++;
      sl |= ~selectStrobeN;
      rs += !pv && &selectStrobeN;
      ub += pu && !upperByteStrobeN;
      if (pu && !upperByteStrobeN) wo = {wo[7:0], extDataOut[15:8]};
      at |= !transferStartStrobeN;
      pv = &selectStrobeN;
      pu = upperByteStrobeN;
    end
    if (rspDone !== 1'b1) errorCnt++;
  endtask : acc
  task wsel(input int n, input logic [31:0] b, input logic [31:0] m, input logic [31:0] c);
    acc(32'h40000080 + 32'(16 * n), 3'h5, 1'b1, SZ_LONG, b);
    acc(32'h40000084 + 32'(16 * n), 3'h5, 1'b1, SZ_LONG, m);
    acc(32'h40000088 + 32'(16 * n), 3'h5, 1'b1, SZ_LONG, c);
  endtask : wsel
  task finishTest;
    $display("checks %0d mismatches %0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finishTest
  initial begin
    #400000;
    errorCnt++;
    finishTest();
  end
  initial begin
    k = $urandom(28);
    // Three edges in reset, since the width strap synchroniser needs two before the last.
    repeat (3) @(posedge ref_clk);
    #5 srst = 0;
    chk(ctlRdata, 32'h0);
    repeat (15) @(posedge ref_clk);
    #5 chk(irqEnable, 1'b0);
    @(posedge ref_clk);
    #5 chk(irqEnable, 1'b1);
    a = 32'h40000010;
    acc(a, 3'($urandom % 7), 1'b0, SZ_LONG, 32'h0);
    chk(lat, elat(2, 7, 0));
    chk(sl, 6'h01);
    chk(rspRdata, {mem(a), mem(a + 32'h2)});
    chk(at, 1);
    d = $urandom;
    ctl(12'hc0f, d);
    chk(ctlRdata, d);
    ctl(12'hc0f, 32'h40000005);
    acc(a, 3'h5, 1'b1, SZ_LONG, 32'hffffffff);
    acc(a, 3'h5, 1'b0, SZ_LONG, 32'h0);
    chk(rspRdata, 32'h0);
    chk(lat, 1);
    acc(a, 3'h1, 1'b0, SZ_WORD, 32'h0);
    chk(lat, elat(1, 7, 0));
    chk(rspRdata, {16'h0, mem(a)});
    wsel(0, 32'h0, 32'hff000000, 32'h11);
    for (k = 0; k < 8; k++) begin
      wsel(1, 32'h10000000, 32'hff000000, 32'h11 + 32'(k * 2));
      a = 32'h10000000 | ($urandom & 32'h00fffffe);
      acc(a, 3'h5, 1'b0, SZ_WORD, 32'h0);
      chk(lat, elat(1, k, 0));
      chk(sl, 6'h02);
      chk(rspRdata, {16'h0, mem(a)});
    end
    acc(32'h70000000, 3'h5, 1'b0, SZ_WORD, 32'h0);
    chk(rspError, 1'b1);
    wsel(5, 32'h10000000, 32'hff000000, 32'h11);
    acc(a, 3'h5, 1'b0, SZ_WORD, 32'h0);
    chk(sl, 6'h20);
    for (k = 0; k < 5; k++) begin
      wsel(2, 32'h20000000, 32'hff000000, 32'h51 + 32'h20 * k[1] + 32'h2 * k[0]);
      a = 32'h20000000 | ($urandom & 32'h00fffffe);
      wv = $urandom;
      acc(a, 3'h5, k == 4, SZ_WORD, wv);
      d = {mem(a), mem(a + 32'h1)};
      chk(lat, elat(2, k[0], k[1]));
      chk(rs, !k[1]);
      chk(ub, k[1] ? 1 : 2);
      if (k < 4) chk(rspRdata, {16'h0, d[31:24], d[15:8]});
      if (k == 4) chk(wo, {16'h0, wv[15:0]});
    end
    wsel(3, 32'hffffff00, 32'hffffff00, 32'h117);
    reqAckCycle = 1;
    for (k = 0; k < 2; k++) begin
      reqAckLevel = 3'($urandom % 7 + 1);
      reqAutovec = k[0];
      acc(32'h0, 3'h0, 1'b0, SZ_BYTE, 32'h0);
      chk(ea, {27'h7ffffff, reqAckLevel, 2'h0});
      chk(sl, 6'h08);
      chk(lat, elat(1, k ? 0 : 3, 0));
      chk(rspAutovec, k[0]);
    end
    chk(rspRdata, 32'h0);
    finishTest();
  end
endmodule : tb_top
`default_nettype wire
